/* File: bcdpo_pkg.sv */
package bcdpo_pkg;

  localparam int          BCDPO_LINES     = 17;
  localparam int          BCDPO_CNT_W     = 26;
  localparam int          BCDPO_CLK_MHZ   = 50;
  localparam int          BCDPO_RATE_W    = 3;

  // update-rate setting codes
  localparam logic [2:0]  BCDPO_RATE_1    = 3'h0;
  localparam logic [2:0]  BCDPO_RATE_10   = 3'h1;
  localparam logic [2:0]  BCDPO_RATE_100  = 3'h2;
  localparam logic [2:0]  BCDPO_RATE_1000 = 3'h3;
  localparam logic [2:0]  BCDPO_RATE_2000 = 3'h4;

  // strobe width in microseconds, half of each update period
  localparam int          BCDPO_STB_US_R4 = 250;
  localparam int          BCDPO_STB_US_R3 = 500;
  localparam int          BCDPO_STB_US_R2 = 5000;
  localparam int          BCDPO_STB_US_R1 = 50000;
  localparam int          BCDPO_STB_US_R0 = 500000;

  localparam int          BCDPO_STB_CYC_R4 = BCDPO_STB_US_R4 * BCDPO_CLK_MHZ;
  localparam int          BCDPO_STB_CYC_R3 = BCDPO_STB_US_R3 * BCDPO_CLK_MHZ;
  localparam int          BCDPO_STB_CYC_R2 = BCDPO_STB_US_R2 * BCDPO_CLK_MHZ;
  localparam int          BCDPO_STB_CYC_R1 = BCDPO_STB_US_R1 * BCDPO_CLK_MHZ;
  localparam int          BCDPO_STB_CYC_R0 = BCDPO_STB_US_R0 * BCDPO_CLK_MHZ;

  // reset values
  localparam logic [16:0] BCDPO_DATA_RST  = 17'h00000;
  localparam logic        BCDPO_BIT_RST   = 1'b0;

endpackage : bcdpo_pkg

/* File: bcdpo_plc_model.sv */
`timescale 1ns/1ps
module bcdpo_plc_model import bcdpo_pkg::*; (
  input  wire logic                   sys_clk,
  input  wire logic                   logic_sel_in,
  input  wire logic [BCDPO_LINES-1:0] digit_on,
  input  wire logic                   minus_on,
  input  wire logic                   strobe_on,
  output logic      [BCDPO_LINES-1:0] got_word,
  output logic                        got_minus
);
  logic      stb_prev = 1'b0;
  // pins turned back into data with the polarity this side holds
  wire logic stb_data = strobe_on ^ ~logic_sel_in;
  always @(posedge sys_clk) begin
    if (stb_prev && !stb_data) begin
      got_word  <= digit_on ^ {BCDPO_LINES{~logic_sel_in}};
      got_minus <= minus_on ^ ~logic_sel_in;
    end
    stb_prev <= stb_data;
  end
endmodule : bcdpo_plc_model

/* File: bcdpo_rate_gen.sv */
`timescale 1ns/1ps
module bcdpo_rate_gen import bcdpo_pkg::*; #(
  parameter int STB_CYC_R4 = BCDPO_STB_CYC_R4,
  parameter int STB_CYC_R3 = BCDPO_STB_CYC_R3,
  parameter int STB_CYC_R2 = BCDPO_STB_CYC_R2,
  parameter int STB_CYC_R1 = BCDPO_STB_CYC_R1,
  parameter int STB_CYC_R0 = BCDPO_STB_CYC_R0
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [BCDPO_RATE_W-1:0] rate_sel,
  input  wire logic                    conv_valid,
  bcdpo_tick_if.gen                    tk
);

  logic [BCDPO_CNT_W-1:0]  cnt_ff,  nxt_cnt;
  logic [BCDPO_RATE_W-1:0] code_ff, nxt_code;
  logic [BCDPO_CNT_W-1:0]  half;

  always_comb begin
    case (rate_sel)
      BCDPO_RATE_1:    half = BCDPO_CNT_W'(STB_CYC_R0);
      BCDPO_RATE_10:   half = BCDPO_CNT_W'(STB_CYC_R1);
      BCDPO_RATE_100:  half = BCDPO_CNT_W'(STB_CYC_R2);
      BCDPO_RATE_1000: half = BCDPO_CNT_W'(STB_CYC_R3);
      default:         half = BCDPO_CNT_W'(STB_CYC_R4);
    endcase
  end

  // fastest rate follows each conversion; slower ones run off a timer
  always_comb begin
    nxt_code = rate_sel;
    nxt_cnt  = cnt_ff + 1'b1;
    tk.tick  = 1'b0;
    if (rate_sel == BCDPO_RATE_2000 || rate_sel > BCDPO_RATE_2000) begin
      tk.tick = conv_valid;
      nxt_cnt = '0;
    end else if (code_ff != rate_sel) begin
      nxt_cnt = '0; // restart the period when the setting changes
    end else if (cnt_ff >= (half << 1) - 1'b1) begin
      tk.tick = 1'b1;
      nxt_cnt = '0;
    end
  end

  assign tk.stb_len = half;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      code_ff <= BCDPO_RATE_2000;
    end else if (clk_en) begin
      cnt_ff  <= nxt_cnt;
      code_ff <= nxt_code;
    end
  end

  default clocking gen_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  conv_follow_a: assert property ((rate_sel == BCDPO_RATE_2000) |-> (tk.tick == conv_valid))
    else $error("fast rate tick not tied to conversion");

endmodule : bcdpo_rate_gen

/* File: bcdpo_tick_if.sv */
`timescale 1ns/1ps
interface bcdpo_tick_if;
  import bcdpo_pkg::*;
  logic                   tick;
  logic [BCDPO_CNT_W-1:0] stb_len;
  modport gen (output tick, output stb_len);
  modport use_side (input tick, input stb_len);
endinterface : bcdpo_tick_if

/* File: bcdpo_top.sv */
`timescale 1ns/1ps
module bcdpo_top import bcdpo_pkg::*; #(
  parameter int STB_CYC_R4 = BCDPO_STB_CYC_R4,
  parameter int STB_CYC_R3 = BCDPO_STB_CYC_R3,
  parameter int STB_CYC_R2 = BCDPO_STB_CYC_R2,
  parameter int STB_CYC_R1 = BCDPO_STB_CYC_R1,
  parameter int STB_CYC_R0 = BCDPO_STB_CYC_R0
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [BCDPO_RATE_W-1:0] rate_sel,
  input  wire logic                    conv_valid,
  input  wire logic [BCDPO_LINES-1:0]  ind_bcd,
  input  wire logic                    ind_minus,
  input  wire logic                    ind_near_zero,
  input  wire logic                    ind_stable,
  input  wire logic                    load_over_neg,
  input  wire logic                    load_over_pos,
  input  wire logic                    overflow_cond_one,
  input  wire logic                    overflow_cond_two,
  input  wire logic                    hold_in,
  input  wire logic                    logic_sel_in,
  output logic      [BCDPO_LINES-1:0]  digit_on,
  output logic                         near_zero_on,
  output logic                         minus_on,
  output logic                         over_on,
  output logic                         stable_on,
  output logic                         strobe_on
);

  typedef enum logic [1:0] {
    BCDPO_ST_IDLE   = 2'h1,
    BCDPO_ST_STROBE = 2'h2
  } bcdpo_state_t;

  bcdpo_tick_if tk ();

  bcdpo_rate_gen #(
    .STB_CYC_R4 (STB_CYC_R4),
    .STB_CYC_R3 (STB_CYC_R3),
    .STB_CYC_R2 (STB_CYC_R2),
    .STB_CYC_R1 (STB_CYC_R1),
    .STB_CYC_R0 (STB_CYC_R0)
  ) u_rate (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .rate_sel   (rate_sel),
    .conv_valid (conv_valid),
    .tk         (tk)
  );

  // latched output word
  logic [BCDPO_LINES-1:0] data_ff,   nxt_data;
  logic                   minus_ff,  nxt_minus;
  logic                   over_ff,   nxt_over;
  logic                   stable_ff, nxt_stable;
  logic                   load;
  logic                   any_over;

  // strobe sequencing
  bcdpo_state_t           state_ff,  nxt_state;
  logic [BCDPO_CNT_W-1:0] stb_cnt_ff, nxt_stb_cnt;
  logic                   strobe_ff, nxt_strobe;

  // pin drivers
  logic [BCDPO_LINES-1:0] pin_data_ff, nxt_pin_data;
  logic                   pin_nz_ff,   nxt_pin_nz;
  logic                   pin_mi_ff,   nxt_pin_mi;
  logic                   pin_ov_ff,   nxt_pin_ov;
  logic                   pin_st_ff,   nxt_pin_st;
  logic                   pin_sb_ff,   nxt_pin_sb;
  logic                   inv;

  assign any_over = load_over_neg | load_over_pos | overflow_cond_one | overflow_cond_two;
  // hold blocks the update itself, so release waits for the next scheduled tick
  assign load     = tk.tick & ~hold_in;

  always_comb begin
    nxt_data   = data_ff;
    nxt_minus  = minus_ff;
    nxt_over   = over_ff;
    nxt_stable = stable_ff;
    if (load) begin
      nxt_data   = ind_bcd;
      nxt_minus  = ind_minus;
      nxt_over   = any_over;
      nxt_stable = ind_stable;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      data_ff   <= BCDPO_DATA_RST;
      minus_ff  <= BCDPO_BIT_RST;
      over_ff   <= BCDPO_BIT_RST;
      stable_ff <= BCDPO_BIT_RST;
    end else if (clk_en) begin
      data_ff   <= nxt_data;
      minus_ff  <= nxt_minus;
      over_ff   <= nxt_over;
      stable_ff <= nxt_stable;
    end
  end

  // strobe rises with the new word and falls half a period later,
  // leaving the receiver a settled word at the falling edge
  always_comb begin
    nxt_state   = state_ff;
    nxt_stb_cnt = stb_cnt_ff;
    nxt_strobe  = strobe_ff;
    case (state_ff)
      BCDPO_ST_IDLE: begin
        if (load) begin
          nxt_state   = BCDPO_ST_STROBE;
          nxt_stb_cnt = tk.stb_len;
          nxt_strobe  = 1'b1;
        end
      end
      BCDPO_ST_STROBE: begin
        if (load) begin
          nxt_stb_cnt = tk.stb_len;
        end else if (stb_cnt_ff <= BCDPO_CNT_W'(1)) begin
          nxt_state   = BCDPO_ST_IDLE;
          nxt_stb_cnt = '0;
          nxt_strobe  = 1'b0;
        end else begin
          nxt_stb_cnt = stb_cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state   = BCDPO_ST_IDLE;
        nxt_stb_cnt = '0;
        nxt_strobe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff   <= BCDPO_ST_IDLE;
      stb_cnt_ff <= '0;
      strobe_ff  <= BCDPO_BIT_RST;
    end else if (clk_en) begin
      state_ff   <= nxt_state;
      stb_cnt_ff <= nxt_stb_cnt;
      strobe_ff  <= nxt_strobe;
    end
  end

  // polarity acts on every line; near zero bypasses the hold and stays live
  assign inv = ~logic_sel_in;

  always_comb begin
    nxt_pin_data = data_ff ^ {BCDPO_LINES{inv}};
    nxt_pin_nz   = ind_near_zero ^ inv;
    nxt_pin_mi   = minus_ff ^ inv;
    nxt_pin_ov   = over_ff ^ inv;
    nxt_pin_st   = stable_ff ^ inv;
    nxt_pin_sb   = strobe_ff ^ inv;
  end

  // after reset pins sit at logic 0 in negative logic, transistors on
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_data_ff <= ~BCDPO_DATA_RST;
      pin_nz_ff   <= ~BCDPO_BIT_RST;
      pin_mi_ff   <= ~BCDPO_BIT_RST;
      pin_ov_ff   <= ~BCDPO_BIT_RST;
      pin_st_ff   <= ~BCDPO_BIT_RST;
      pin_sb_ff   <= ~BCDPO_BIT_RST;
    end else if (clk_en) begin
      pin_data_ff <= nxt_pin_data;
      pin_nz_ff   <= nxt_pin_nz;
      pin_mi_ff   <= nxt_pin_mi;
      pin_ov_ff   <= nxt_pin_ov;
      pin_st_ff   <= nxt_pin_st;
      pin_sb_ff   <= nxt_pin_sb;
    end
  end

  assign digit_on     = pin_data_ff;
  assign near_zero_on = pin_nz_ff;
  assign minus_on     = pin_mi_ff;
  assign over_on      = pin_ov_ff;
  assign stable_on    = pin_st_ff;
  assign strobe_on    = pin_sb_ff;

  default clocking top_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  hold_freeze_a: assert property ((clk_en && hold_in) |=> $stable(data_ff))
    else $error("output word changed while held");

  word_load_a: assert property ((clk_en && load) |=> (data_ff == $past(ind_bcd)))
    else $error("new word not taken on update");

  pin_polarity_a: assert property (
    (clk_en && logic_sel_in) |=> (digit_on == $past(data_ff)))
    else $error("positive logic pins wrong");

  neg_polarity_a: assert property (
    (clk_en && !logic_sel_in) |=> (digit_on == ~$past(data_ff)))
    else $error("negative logic pins wrong");

  near_zero_a: assert property (
    clk_en |=> (near_zero_on == ($past(ind_near_zero) ^ ~$past(logic_sel_in))))
    else $error("near zero pin not live");

  sign_with_data_a: assert property ((clk_en && load) |=> (minus_ff == $past(ind_minus)))
    else $error("sign not latched with word");

  stable_with_data_a: assert property ((clk_en && load) |=> (stable_ff == $past(ind_stable)))
    else $error("stable not latched with word");

  over_any_a: assert property ((clk_en && load) |=> (over_ff == $past(any_over)))
    else $error("over not raised for over-scale");

  strobe_start_a: assert property ((clk_en && load) |=> strobe_ff)
    else $error("no strobe with update");

  no_extra_strobe_a: assert property (!(clk_en && load) |=> !$rose(strobe_ff))
    else $error("strobe rose without update");

  strobe_end_a: assert property (
    (clk_en && strobe_ff && !load && stb_cnt_ff == BCDPO_CNT_W'(1)) |=> !strobe_ff)
    else $error("strobe width wrong");

  hold_live_a: assert property (
    (clk_en && hold_in) |=> (near_zero_on == ($past(ind_near_zero) ^ ~$past(logic_sel_in))))
    else $error("near zero pin frozen by hold");

  sign_pin_a: assert property (
    clk_en |=> (minus_on == ($past(minus_ff) ^ ~$past(logic_sel_in))))
    else $error("sign pin does not follow latched sign");

  over_pin_a: assert property (
    clk_en |=> (over_on == ($past(over_ff) ^ ~$past(logic_sel_in))))
    else $error("over pin does not follow latched over");

  stable_pin_a: assert property (
    clk_en |=> (stable_on == ($past(stable_ff) ^ ~$past(logic_sel_in))))
    else $error("stable pin does not follow latched stable");

  strobe_pin_a: assert property (
    clk_en |=> (strobe_on == ($past(strobe_ff) ^ ~$past(logic_sel_in))))
    else $error("strobe pin out of step with word");

  strobe_len_a: assert property ((clk_en && load) |=> (stb_cnt_ff == $past(tk.stb_len)))
    else $error("strobe width not taken from setting");

  strobe_hold_a: assert property (
    (clk_en && strobe_ff && !load && stb_cnt_ff > BCDPO_CNT_W'(1)) |=> strobe_ff)
    else $error("strobe ended early");

  idle_low_a: assert property ((state_ff == BCDPO_ST_IDLE) |-> !strobe_ff)
    else $error("strobe high while idle");

  retrig_a: assert property ((clk_en && strobe_ff && load) |=> strobe_ff)
    else $error("strobe dropped on back-to-back update");

  // outside an update the latched word and its status must not move
  word_keep_a: assert property (
    (clk_en && !load) |=> ($stable(data_ff) && $stable(minus_ff) &&
                           $stable(over_ff) && $stable(stable_ff)))
    else $error("word changed without update");

  // fastest and slowest codes pick the outer strobe widths
  fast_len_a: assert property (
    (rate_sel == BCDPO_RATE_2000) |-> (tk.stb_len == BCDPO_CNT_W'(STB_CYC_R4)))
    else $error("fastest code strobe width wrong");

  slow_len_a: assert property (
    (rate_sel == BCDPO_RATE_1) |-> (tk.stb_len == BCDPO_CNT_W'(STB_CYC_R0)))
    else $error("slowest code strobe width wrong");

  // a low enable must leave the word, the digit and strobe pins and the strobe timing untouched
  enable_freeze_a: assert property (
    !clk_en |=> ($stable(data_ff) && $stable(stb_cnt_ff) &&
                 $stable(digit_on) && $stable(strobe_on)))
    else $error("state moved with enable low");

  hold_update_c: cover property (hold_in ##1 !hold_in ##[1:1000] load);
  slow_rate_c:   cover property ((rate_sel == BCDPO_RATE_1000) && load);
  over_show_c:   cover property (load && any_over && logic_sel_in);
  neg_logic_c:   cover property (load && !logic_sel_in);
  retrigger_c:   cover property (strobe_ff && load);

endmodule : bcdpo_top

/* File: bcdpo_top_tb_top.sv */
`timescale 1ns/1ps
module bcdpo_top_tb_top import bcdpo_pkg::*;;
  logic                   sys_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [BCDPO_RATE_W-1:0] rate_sel = 3'h4;
  logic                   conv_valid = 1'b0;
  logic [BCDPO_LINES-1:0] ind_bcd = 17'h00000;
  logic                   ind_minus = 1'b0;
  logic                   ind_near_zero = 1'b0;
  logic                   ind_stable = 1'b0;
  logic [3:0]             ovr = 4'h0;
  logic                   hold_in = 1'b0;
  logic                   clk_en = 1'b1;
  logic                   logic_sel_in = 1'b0;
  logic [BCDPO_LINES-1:0] digit_on, got_word;
  logic                   near_zero_on, minus_on, over_on, stable_on, strobe_on, got_minus;
  int                     bad_count = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     n;

  bcdpo_top #(.STB_CYC_R4(4), .STB_CYC_R3(8), .STB_CYC_R2(16), .STB_CYC_R1(32),
              .STB_CYC_R0(64)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .rate_sel(rate_sel),
    .conv_valid(conv_valid), .ind_bcd(ind_bcd), .ind_minus(ind_minus),
    .ind_near_zero(ind_near_zero), .ind_stable(ind_stable), .load_over_neg(ovr[0]),
    .load_over_pos(ovr[1]), .overflow_cond_one(ovr[2]), .overflow_cond_two(ovr[3]),
    .hold_in(hold_in), .logic_sel_in(logic_sel_in), .digit_on(digit_on),
    .near_zero_on(near_zero_on), .minus_on(minus_on), .over_on(over_on),
    .stable_on(stable_on), .strobe_on(strobe_on));

  bcdpo_plc_model u_plc (
    .sys_clk(sys_clk), .logic_sel_in(logic_sel_in), .digit_on(digit_on),
    .minus_on(minus_on), .strobe_on(strobe_on), .got_word(got_word), .got_minus(got_minus));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // every test is short at the reduced strobe counts, so a few thousand cycles is ample
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : step

  // word loads on the edge that sees the pulse, pins one edge later
  task automatic conv(input logic [16:0] v);
    @(posedge sys_clk);
    ind_bcd    <= v;
    conv_valid <= 1'b1;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    step(1);
  endtask : conv

  task automatic rise(output int k);
    k = 0;
    while (strobe_on !== 1'b0) begin step(1); k++; end
    while (strobe_on !== 1'b1) begin step(1); k++; end
  endtask : rise

  task automatic t_update;
    @(posedge sys_clk);
    logic_sel_in <= 1'b1;
    ind_minus    <= 1'b1;
    ind_stable   <= 1'b1;
    conv(17'h12345);
    chk(digit_on, 17'h12345);
    chk(17'(minus_on), 17'h1);
    chk(17'(stable_on), 17'h1);
    chk(17'(strobe_on), 17'h1);
    step(10);
    chk(got_word, 17'h12345);
    chk(17'(got_minus), 17'h1);
    @(posedge sys_clk);
    logic_sel_in <= 1'b0;
    step(2);
    chk(digit_on, ~17'h12345);
    chk(17'(minus_on), 17'h0);
    @(posedge sys_clk);
    logic_sel_in <= 1'b1;
    $display("update and polarity done");
  endtask : t_update

  task automatic t_over;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      ovr        <= (i < 4) ? 4'(1 << i) : 4'h0;
      ind_stable <= (i != 1);
      conv(17'h00001);
      chk(17'(over_on), (i < 4) ? 17'h1 : 17'h0);
      chk(17'(stable_on), (i != 1) ? 17'h1 : 17'h0);
      step(8);
    end
    $display("over sources done");
  endtask : t_over

  task automatic t_hold;
    @(posedge sys_clk);
    hold_in       <= 1'b1;
    ind_near_zero <= 1'b1;
    step(2);
    conv(17'h09876);
    chk(digit_on, 17'h00001);
    chk(17'(near_zero_on), 17'h1);
    @(posedge sys_clk);
    hold_in <= 1'b0;
    step(2);
    chk(17'(strobe_on), 17'h0);
    chk(digit_on, 17'h00001);
    step(4);
    conv(17'h04321);
    chk(digit_on, 17'h04321);
    step(8);
    $display("hold done");
  endtask : t_hold

  // with the enable low a conversion is lost and no pin moves, polarity included
  task automatic t_freeze;
    @(posedge sys_clk);
    clk_en       <= 1'b0;
    logic_sel_in <= 1'b0;
    conv(17'h05555);
    chk(digit_on, 17'h04321);
    chk(17'(strobe_on), 17'h0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    step(2);
    chk(digit_on, ~17'h04321);
    chk(17'(strobe_on), 17'h1);
    @(posedge sys_clk);
    logic_sel_in <= 1'b1;
    $display("clock enable freeze done");
  endtask : t_freeze

  task automatic t_rate;
    int half [4] = '{64, 32, 16, 8};
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      rate_sel <= 3'(c);
      rise(n);
      rise(n);
      chk(17'(n), 17'(2 * half[c]));
    end
    @(posedge sys_clk);
    rate_sel <= 3'h5;
    conv(17'h00777);
    chk(digit_on, 17'h00777);
    @(posedge sys_clk);
    rate_sel <= 3'h4;
    $display("rate codes done");
  endtask : t_rate

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    step(2);
    chk(digit_on, 17'h1FFFF);
    t_update();
    t_over();
    t_hold();
    t_freeze();
    t_rate();
    wrap_up();
  end
endmodule : bcdpo_top_tb_top
